// ### hw/uaf_pkg.sv
package uaf_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] ADDR_SCTL = 8'h00;
    localparam logic [7:0] ADDR_RXBUF = 8'h04;
    localparam logic [7:0] ADDR_PCTL = 8'h08;
    localparam logic [7:0] ADDR_SADR = 8'h0c;
    localparam logic [7:0] ADDR_SMSK = 8'h10;
    localparam logic [7:0] ADDR_BAUD = 8'h14;

    // serial_control_reg field positions
    localparam int SC_MODE0 = 7;
    localparam int SC_MODE1 = 6;
    localparam int SC_MPE = 5;
    localparam int SC_REN = 4;
    localparam int SC_TX9 = 3;
    localparam int SC_RX9 = 2;
    localparam int SC_RXDONE = 0;

    // power_control_reg field positions
    localparam int PC_DBL = 7;
    localparam int PC_FESEL = 6;

    // reset values
    localparam logic [7:0] SADR_RST = 8'h00;
    localparam logic [7:0] SMSK_RST = 8'h00;
    localparam logic [15:0] BAUD_RST = 16'h0004;

    // port modes, index is {mode_select_bit1, mode_select_bit0}
    localparam logic [1:0] MODE_SHIFT = 2'h0;
    localparam logic [1:0] MODE_8BIT = 2'h1;
    localparam logic [1:0] MODE_FIXED = 2'h2;
    localparam logic [1:0] MODE_VAR9 = 2'h3;

    // fixed-rate mode: pclk cycles per 1/16 bit (rate /64 or /32)
    localparam logic [15:0] FIX_DIV_SLOW = 16'h0004;
    localparam logic [15:0] FIX_DIV_FAST = 16'h0002;

    // bit detector: three sample states, then the vote
    localparam logic [3:0] SAMP_A = 4'h7;
    localparam logic [3:0] SAMP_B = 4'h8;
    localparam logic [3:0] SAMP_C = 4'h9;
    localparam logic [3:0] SAMP_VOTE = 4'ha;
    localparam logic [3:0] LAST_BIT8 = 4'h7;
    localparam logic [3:0] LAST_BIT9 = 4'h8;
    localparam logic [8:0] SHIFT_INIT = 9'h1ff;

    // one received frame as the bit detector hands it over
    typedef struct packed {
        logic [7:0] data;
        logic ninth;
        logic stop;
    } uaf_frame_t;
endpackage : uaf_pkg

// ### hw/uaf_rx_filter.sv
// Contract
// - With frame error detection selected, a frame whose stop bit is missing sets the flag.
// - Control bit 7 reads as the frame error flag when the select is 1, else mode bit 0.
// - The frame error flag is cleared only by a software write, never by hardware.
// - Nine-bit modes take nine data bits and a stop bit; the ninth goes to rx_ninth_bit.
// - Nine-bit modes with multiproc_enable set raise rx_done_flag only when the ninth is 1.
// - In shift-register mode 0 the multiprocessor enable has no effect on reception.
// - Mode 1 with multiproc_enable set withholds rx_done_flag unless the stop bit is valid.
// - Modes 2 and 3 with filtering set rx_done_flag only for ninth 1 and an address match.
// - Mode 1 with filtering sets rx_done_flag only for a good stop bit and an address match.
// - The given address compares slave address bits only where the mask holds 1.
// - The broadcast address is address OR mask; its zero bits are don't-care.
// - Reset clears address and mask to zero, so every byte matches.
// - A frame loads buffer and ninth bit and sets rx_done_flag only if that flag was 0.
// - Mode 2 is selected by mode bit 1 high and mode bit 0 low.
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ps
module uaf_rx_filter #(
    parameter int BAUD_W = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line and status
    input wire logic rx_pin,
    output logic rx_done
);
    logic rx_meta_r;
    logic rx_sync_r;
    logic mode0_r;
    logic mode1_r;
    logic mpe_r;
    logic ren_r;
    logic tx_ninth_r;
    logic ninth_r;
    logic rxd_flag_r;
    logic frm_err_r;
    logic fesel_r;
    logic dbl_r;
    logic [7:0] rxbuf_r;
    logic [7:0] slave_address_reg_r;
    logic [7:0] smask_r;
    logic [BAUD_W-1:0] baud_r;
    logic [BAUD_W-1:0] cnt_r;
    logic tick_r;
    logic [1:0] mode;
    logic nine;
    logic rx_on;
    logic [BAUD_W-1:0] div;
    logic frame_done;
    uaf_pkg::uaf_frame_t frame;
    logic given_hit;
    logic bcast_hit;
    logic addr_hit;
    logic [7:0] bcast;
    logic qualify;
    logic accept;
    logic apb_wr;
    logic wr_sctl;
    logic sc7_view;

    // line synchroniser, the first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta_r <= 1'b1;
            rx_sync_r <= 1'b1;
        end else begin
            rx_meta_r <= rx_pin;
            rx_sync_r <= rx_meta_r;
        end
    end

    // mode decode and reception enable
    assign mode = {mode1_r, mode0_r};
    assign nine = (mode == uaf_pkg::MODE_FIXED) || (mode == uaf_pkg::MODE_VAR9);
    // shift-register mode is not received here, so the enable bit cannot matter
    assign rx_on = ren_r && (mode != uaf_pkg::MODE_SHIFT);
    assign sc7_view = fesel_r ? frm_err_r : mode0_r;

    // 16x rate: fixed in mode 2, programmable divisor otherwise
    assign div = (mode == uaf_pkg::MODE_FIXED) ?
        (dbl_r ? BAUD_W'(uaf_pkg::FIX_DIV_FAST) : BAUD_W'(uaf_pkg::FIX_DIV_SLOW)) : baud_r;

    // divider; a divisor of 0 behaves as 1 instead of hanging
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else if ({1'b0, cnt_r} + 1'b1 >= {1'b0, div}) begin
            cnt_r <= '0;
            tick_r <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick_r <= 1'b0;
        end
    end

    uaf_rx_frame u_uaf_rx_frame (
        .pclk(pclk),
        .presetn(presetn),
        .rx_sync(rx_sync_r),
        .tick16(tick_r),
        .enable(rx_on),
        .nine_bits(nine),
        .frame_done(frame_done),
        .frame(frame)
    );

    // address recognition against given and broadcast addresses
    assign given_hit = ((frame.data ^ slave_address_reg_r) & smask_r) == 8'h00;
    assign bcast = slave_address_reg_r | smask_r;
    assign bcast_hit = (~frame.data & bcast) == 8'h00;
    assign addr_hit = given_hit | bcast_hit;

    // frame qualification; filtering uses the ninth bit or the stop bit
    always_comb begin
        qualify = 1'b1;
        if (mpe_r) begin
            if (nine) begin
                qualify = frame.ninth && addr_hit;
            end else begin
                qualify = frame.stop && addr_hit;
            end
        end
    end
    // an unread byte is never overwritten; the new frame is dropped
    assign accept = frame_done && !rxd_flag_r && qualify;

    // apb write strobe, taken in the access cycle only
    assign apb_wr = psel && penable && pwrite && pready;
    assign wr_sctl = apb_wr && (paddr == uaf_pkg::ADDR_SCTL);

    // serial_control_reg plain bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode0_r <= 1'b0;
            mode1_r <= 1'b0;
            mpe_r <= 1'b0;
            ren_r <= 1'b0;
            tx_ninth_r <= 1'b0;
        end else if (wr_sctl) begin
            if (!fesel_r) begin
                mode0_r <= pwdata[uaf_pkg::SC_MODE0];
            end
            mode1_r <= pwdata[uaf_pkg::SC_MODE1];
            mpe_r <= pwdata[uaf_pkg::SC_MPE];
            ren_r <= pwdata[uaf_pkg::SC_REN];
            tx_ninth_r <= pwdata[uaf_pkg::SC_TX9];
        end
    end

    // receive results: hardware load wins over a write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxd_flag_r <= 1'b0;
            ninth_r <= 1'b0;
            rxbuf_r <= 8'h00;
        end else if (accept) begin
            rxd_flag_r <= 1'b1;
            ninth_r <= frame.ninth;
            rxbuf_r <= frame.data;
        end else if (wr_sctl) begin
            rxd_flag_r <= pwdata[uaf_pkg::SC_RXDONE];
            ninth_r <= pwdata[uaf_pkg::SC_RX9];
        end
    end

    // frame error flag: sticky, the set beats a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_err_r <= 1'b0;
        end else if (frame_done && !frame.stop && fesel_r) begin
            frm_err_r <= 1'b1;
        end else if (wr_sctl && fesel_r) begin
            frm_err_r <= pwdata[uaf_pkg::SC_MODE0];
        end
    end

    // power_control_reg, address registers and divisor
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fesel_r <= 1'b0;
            dbl_r <= 1'b0;
            slave_address_reg_r <= uaf_pkg::SADR_RST;
            smask_r <= uaf_pkg::SMSK_RST;
            baud_r <= BAUD_W'(uaf_pkg::BAUD_RST);
        end else if (apb_wr) begin
            case (paddr)
                uaf_pkg::ADDR_PCTL: begin
                    fesel_r <= pwdata[uaf_pkg::PC_FESEL];
                    dbl_r <= pwdata[uaf_pkg::PC_DBL];
                end
                uaf_pkg::ADDR_SADR: slave_address_reg_r <= pwdata[7:0];
                uaf_pkg::ADDR_SMSK: smask_r <= pwdata[7:0];
                uaf_pkg::ADDR_BAUD: baud_r <= pwdata[BAUD_W-1:0];
                default: ;
            endcase
        end
    end

    // apb answer: read data latched in setup, pready high for one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                prdata <= 32'h0000_0000;
                case (paddr)
                    uaf_pkg::ADDR_SCTL: prdata[7:0] <= {sc7_view, mode1_r, mpe_r, ren_r,
                                                       tx_ninth_r, ninth_r, 1'b0,
                                                       rxd_flag_r};
                    uaf_pkg::ADDR_RXBUF: prdata[7:0] <= rxbuf_r;
                    uaf_pkg::ADDR_PCTL: prdata[7:0] <= {dbl_r, fesel_r, 6'h00};
                    uaf_pkg::ADDR_SADR: prdata[7:0] <= slave_address_reg_r;
                    uaf_pkg::ADDR_SMSK: prdata[7:0] <= smask_r;
                    uaf_pkg::ADDR_BAUD: prdata[BAUD_W-1:0] <= baud_r;
                    default: pslverr <= 1'b1; // unmapped
                endcase
            end
        end
    end

    // receive-done level out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_done <= 1'b0;
        end else begin
            rx_done <= rxd_flag_r || accept;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // helper: frame arrives while no write touches the control register
    logic quiet_frame;
    assign quiet_frame = frame_done && !wr_sctl;

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable && pready;
    endsequence

    sequence s_good_load;
        accept ##1 (rxd_flag_r && rx_done);
    endsequence

    a_apb_answer: assert property (
        s_setup |=> s_access or !psel)
        else $error("apb access phase did not see pready");

    // a clear written in the cycle after the set takes effect one cycle later
    a_ferr_set: assert property (
        frame_done && !frame.stop && fesel_r
        |=> frm_err_r ##1 (frm_err_r || $past(wr_sctl)))
        else $error("frame error flag not set on missing stop bit");

    a_bit7_view: assert property (
        s_setup and paddr == uaf_pkg::ADDR_SCTL |=> prdata[7] == $past(sc7_view))
        else $error("control bit 7 shows wrong function");

    a_ferr_sticky: assert property (
        frm_err_r && !(wr_sctl && !pwdata[uaf_pkg::SC_MODE0]) |=> frm_err_r)
        else $error("frame error flag cleared by hardware");

    a_ninth_load: assert property (
        accept && nine |=> ninth_r == $past(frame.ninth))
        else $error("ninth bit not loaded");

    a_nine_filter: assert property (
        quiet_frame && mpe_r && nine && !frame.ninth |=> rxd_flag_r == $past(rxd_flag_r))
        else $error("data byte raised receive flag");

    a_mode0_quiet: assert property (
        (mode == uaf_pkg::MODE_SHIFT) [*2] |-> !frame_done)
        else $error("frame received in shift-register mode");

    a_stop_check: assert property (
        quiet_frame && mpe_r && mode == uaf_pkg::MODE_8BIT && !frame.stop
        |=> rxd_flag_r == $past(rxd_flag_r))
        else $error("bad stop bit raised receive flag");

    a_addr_gate: assert property (
        quiet_frame && mpe_r && nine && !addr_hit |=> rxd_flag_r == $past(rxd_flag_r))
        else $error("unmatched address raised receive flag");

    a_addr_mode1: assert property (
        quiet_frame && mpe_r && !nine && frame.stop && addr_hit && !rxd_flag_r
        |-> s_good_load)
        else $error("matching address in mode 1 not taken");

    a_given_match: assert property (
        frame_done && smask_r == 8'hff && frame.data == slave_address_reg_r |-> addr_hit)
        else $error("exact given address not matched");

    a_bcast_match: assert property (
        frame_done && frame.data == 8'hff |-> addr_hit)
        else $error("all-ones byte missed broadcast");

    a_reset_open: assert property (
        slave_address_reg_r == 8'h00 && smask_r == 8'h00 |-> addr_hit)
        else $error("cleared filter rejected a byte");

    // a software clear in the same cycle is allowed to drop the flag
    a_busy_drop: assert property (
        quiet_frame && rxd_flag_r |=> rxbuf_r == $past(rxbuf_r) && rxd_flag_r)
        else $error("frame overwrote unread buffer");

    a_drop_ninth: assert property (
        quiet_frame && rxd_flag_r |=> ninth_r == $past(ninth_r))
        else $error("dropped frame changed ninth bit");

    // the access cycle is never stretched, so pready is a single pulse
    a_ready_pulse: assert property (
        pready |=> !pready)
        else $error("pready held for two cycles");

    a_ferr_unused: assert property (
        !fesel_r |=> frm_err_r == $past(frm_err_r))
        else $error("frame error flag moved while bit 7 is the mode bit");

    a_mode2_rate: assert property (
        tick_r && mode == uaf_pkg::MODE_FIXED && !dbl_r && !apb_wr
        |=> !tick_r ##1 (!tick_r || apb_wr))
        else $error("fixed-rate tick spacing wrong");

    a_stop_vote: assert property (
        frame_done && frame.stop && fesel_r && !frm_err_r && !wr_sctl |=> !frm_err_r)
        else $error("good stop bit flagged as frame error");
endmodule : uaf_rx_filter

// ### hw/uaf_rx_frame.sv
`timescale 1ns/1ps
module uaf_rx_frame (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // synchronised line and 16x timing
    input wire logic rx_sync,
    input wire logic tick16,
    input wire logic enable,
    input wire logic nine_bits,
    // completed frame
    output logic frame_done,
    output uaf_pkg::uaf_frame_t frame
);
    typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} uaf_rx_state_t;

    uaf_rx_state_t state_r;
    logic [3:0] phase_r;
    logic [2:0] samp_r;
    logic [8:0] shift_r;
    logic [3:0] nbit_r;
    logic line_prev_r;
    logic vote;
    logic [3:0] last_bit;

    // two of three samples win, which rejects short noise spikes
    assign vote = (samp_r[0] & samp_r[1]) | (samp_r[0] & samp_r[2]) | (samp_r[1] & samp_r[2]);
    assign last_bit = nine_bits ? uaf_pkg::LAST_BIT9 : uaf_pkg::LAST_BIT8;

    // line level at the previous tick, for start edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_prev_r <= 1'b1;
        end else if (tick16) begin
            line_prev_r <= rx_sync;
        end
    end

    // bit timing, sampling and shifting of one frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            phase_r <= 4'h0;
            samp_r <= 3'h7;
            shift_r <= uaf_pkg::SHIFT_INIT;
            nbit_r <= 4'h0;
            frame_done <= 1'b0;
            frame <= '0;
        end else begin
            frame_done <= 1'b0;
            if (!enable) begin
                state_r <= ST_IDLE;
            end else if (tick16) begin
                phase_r <= phase_r + 4'h1;
                if (phase_r == uaf_pkg::SAMP_A || phase_r == uaf_pkg::SAMP_B ||
                    phase_r == uaf_pkg::SAMP_C) begin
                    samp_r <= {rx_sync, samp_r[2:1]};
                end
                case (state_r)
                    ST_IDLE: begin
                        // counter restarts on the edge so bit cells line up
                        if (line_prev_r && !rx_sync) begin
                            state_r <= ST_START;
                            phase_r <= 4'h1;
                            shift_r <= uaf_pkg::SHIFT_INIT;
                        end
                    end
                    ST_START: begin
                        if (phase_r == uaf_pkg::SAMP_VOTE) begin
                            nbit_r <= 4'h0;
                            state_r <= vote ? ST_IDLE : ST_DATA; // false start rejected
                        end
                    end
                    ST_DATA: begin
                        if (phase_r == uaf_pkg::SAMP_VOTE) begin
                            shift_r <= {vote, shift_r[8:1]}; // lsb first
                            nbit_r <= nbit_r + 4'h1;
                            if (nbit_r == last_bit) begin
                                state_r <= ST_STOP;
                            end
                        end
                    end
                    ST_STOP: begin
                        if (phase_r == uaf_pkg::SAMP_VOTE) begin
                            frame_done <= 1'b1;
                            frame.stop <= vote;
                            frame.data <= nine_bits ? shift_r[7:0] : shift_r[8:1];
                            frame.ninth <= nine_bits ? shift_r[8] : vote;
                            state_r <= ST_IDLE;
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
        end
    end
endmodule : uaf_rx_frame

// ### testbench/test_uart_rx_address_filter.sv
`timescale 1ns/1ps
module test_uart_rx_address_filter;
    // 16 ticks of the reset divisor; mode 2 at the slow rate gives the same bit time
    localparam int BIT_T = 64;
    // address table for modes 2 and 3, with slave address e0 and mask fa
    localparam logic [7:0] TDAT [6] = '{8'he5, 8'he5, 8'he6, 8'hfa, 8'hff, 8'h00};
    localparam logic [5:0] TMPE = 6'h1f;
    localparam logic [5:0] TNIN = 6'h1d;
    localparam logic [5:0] TACC = 6'h39;
    logic pclk;
    logic presetn;
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_pin;
    logic rx_done;
    logic [32:0] exp_q [$];
    logic [32:0] exp_now;
    int err_total;
    int total_checks;

    uaf_rx_filter #(.BAUD_W(16)) u_uaf_rx_filter (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin),
        .rx_done(rx_done));
    uaf_line_master u_uaf_line_master (.pclk(pclk), .rx_pin(rx_pin));

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t read %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        if (err_total == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // one apb transfer; a read notes its expected {pslverr, prdata} first
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                       input logic [32:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        if (!w) exp_q.push_back(exp);
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 33'h0_0000_0000);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        apb(a, 1'b0, 32'h0000_0000, {17'h0_0000, e});
    endtask : rd

    // send a frame, then give the flag a bounded time to rise
    task automatic frame(input logic [7:0] d, input logic ninth, input logic nine,
                         input logic stop);
        u_uaf_line_master.send(d, ninth, nine, stop, BIT_T);
        for (int i = 0; i < 120 && rx_done !== 1'b1; i++) @(posedge pclk);
    endtask : frame

    // watcher pairs each completed read with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            exp_now = exp_q.pop_front();
            check({pslverr, prdata}, exp_now);
            // the level output must agree with the done flag noted for this read
            if (paddr == uaf_pkg::ADDR_SCTL) begin
                check({32'h0000_0000, rx_done}, {32'h0000_0000, exp_now[0]});
            end
        end
    end

    // frames take about 700 cycles each and there are about twenty
    initial begin
        repeat (60000) @(posedge pclk);
        err_total++;
        complete_run();
    end

    initial begin
        logic [7:0] d;
        logic [7:0] ctl;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        err_total = 0;
        total_checks = 0;
        void'($urandom(85981));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then an unmapped word that must be refused
        rd(uaf_pkg::ADDR_SCTL, 16'h0000);
        rd(uaf_pkg::ADDR_SADR, 16'h0000);
        rd(uaf_pkg::ADDR_SMSK, 16'h0000);
        rd(uaf_pkg::ADDR_BAUD, 16'h0004);
        apb(8'h18, 1'b0, 32'h0000_0000, {1'b1, 32'h0000_0000});
        // mode 1: a good frame loads, a second one while the flag is up is lost
        wr(uaf_pkg::ADDR_SCTL, 32'h0000_0090);
        d = 8'($urandom);
        frame(d, 1'b0, 1'b0, 1'b1);
        rd(uaf_pkg::ADDR_SCTL, 16'h0095);
        frame(~d, 1'b0, 1'b0, 1'b1);
        rd(uaf_pkg::ADDR_RXBUF, {8'h00, d});
        // with the error select set, bit 7 shows the error flag, not the mode bit
        wr(uaf_pkg::ADDR_PCTL, 32'h0000_0040);
        rd(uaf_pkg::ADDR_SCTL, 16'h0015);
        wr(uaf_pkg::ADDR_SCTL, 32'h0000_0010);
        d = 8'($urandom);
        frame(d, 1'b0, 1'b0, 1'b0);
        rd(uaf_pkg::ADDR_SCTL, 16'h0091);
        rd(uaf_pkg::ADDR_RXBUF, {8'h00, d});
        wr(uaf_pkg::ADDR_SCTL, 32'h0000_0090);
        frame(~d, 1'b0, 1'b0, 1'b1);
        rd(uaf_pkg::ADDR_SCTL, 16'h0095);
        wr(uaf_pkg::ADDR_SCTL, 32'h0000_0010);
        rd(uaf_pkg::ADDR_SCTL, 16'h0010);
        wr(uaf_pkg::ADDR_PCTL, 32'h0000_0000);
        rd(uaf_pkg::ADDR_SCTL, 16'h0090);
        // mode 1 with multiprocessor enable: bad stop withheld, any byte matches at reset
        wr(uaf_pkg::ADDR_SCTL, 32'h0000_00b0);
        frame(d, 1'b0, 1'b0, 1'b0);
        rd(uaf_pkg::ADDR_SCTL, 16'h00b0);
        d = 8'($urandom);
        frame(d, 1'b0, 1'b0, 1'b1);
        rd(uaf_pkg::ADDR_SCTL, 16'h00b5);
        rd(uaf_pkg::ADDR_RXBUF, {8'h00, d});
        // nine-bit modes: given, broadcast, data bytes and plain reception
        wr(uaf_pkg::ADDR_SADR, 32'h0000_00e0);
        wr(uaf_pkg::ADDR_SMSK, 32'h0000_00fa);
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 6; k++) begin
                ctl = ((m == 0) ? 8'h40 : 8'hc0) | 8'h10 | (TMPE[k] ? 8'h20 : 8'h00);
                d = (k == 5) ? 8'($urandom) : TDAT[k];
                wr(uaf_pkg::ADDR_SCTL, {24'h00_0000, ctl});
                frame(d, TNIN[k], 1'b1, 1'b1);
                if (TACC[k]) begin
                    rd(uaf_pkg::ADDR_SCTL, {8'h00, ctl | {5'h00, TNIN[k], 2'h1}});
                    rd(uaf_pkg::ADDR_RXBUF, {8'h00, d});
                end else begin
                    rd(uaf_pkg::ADDR_SCTL, {8'h00, ctl});
                end
            end
        end
        // fixed-rate mode with the rate doubled: a frame sent at half the bit time decodes
        wr(uaf_pkg::ADDR_PCTL, 32'h0000_0080);
        wr(uaf_pkg::ADDR_SCTL, 32'h0000_0050);
        u_uaf_line_master.send(8'h3c, 1'b1, 1'b1, 1'b1, BIT_T / 2);
        rd(uaf_pkg::ADDR_SCTL, 16'h0055);
        rd(uaf_pkg::ADDR_RXBUF, 16'h003c);
        // shift-register mode: the receiver stays idle whatever the enable says
        wr(uaf_pkg::ADDR_SCTL, 32'h0000_0030);
        frame(8'h55, 1'b0, 1'b0, 1'b1);
        rd(uaf_pkg::ADDR_SCTL, 16'h0030);
        repeat (4) @(posedge pclk);
        complete_run();
    end
endmodule : test_uart_rx_address_filter

// ### testbench/uaf_line_master.sv
`timescale 1ns/1ps
// far-end serial node: drives whole frames onto the receive line
module uaf_line_master (
    // clock
    input wire logic pclk,
    // serial line, idle high as a pulled-up line would rest
    output logic rx_pin
);
    initial rx_pin = 1'b1;

    // start bit, eight data bits lsb first, optional ninth bit, stop bit
    task automatic send(input logic [7:0] d, input logic ninth, input logic nine,
                        input logic stop, input int bt);
        @(posedge pclk);
        rx_pin <= 1'b0;
        repeat (bt) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            rx_pin <= d[i];
            repeat (bt) @(posedge pclk);
        end
        if (nine) begin
            rx_pin <= ninth;
            repeat (bt) @(posedge pclk);
        end
        // a low stop bit models a broken frame; the line then rises without a new start
        rx_pin <= stop;
        repeat (bt) @(posedge pclk);
        rx_pin <= 1'b1;
    endtask : send
endmodule : uaf_line_master
